// ==== rtl/fvbp_pkg.sv ====
// Purpose: Shared constants for the flyback valley, burst and protection core
// Assumes: 25 MHz core clock
// Notes: Analog levels are comparator thresholds outside; kept here as reference
package fvbp_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned CNT_W = 20;
  // Times in their own unit, cycle counts derived
  localparam int unsigned LEB_NS = 160;
  localparam int unsigned LEB_CYC = (LEB_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HARD_WIN_NS = 150;
  localparam int unsigned HARD_WIN_CYC = HARD_WIN_NS / CLK_NS;
  localparam int unsigned OFF_MAX_US = 47;
  localparam int unsigned OFF_MAX_CYC = OFF_MAX_US * 1000 / CLK_NS;
  localparam int unsigned SUPPLY_BLANK_US = 1;
  localparam int unsigned SUPPLY_BLANK_CYC = (SUPPLY_BLANK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OTP_BLANK_US = 18;
  localparam int unsigned OTP_BLANK_CYC = (OTP_BLANK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LSOV_BLANK_US = 20;
  localparam int unsigned LSOV_BLANK_CYC = (LSOV_BLANK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OVP_BLANK_US = 100;
  localparam int unsigned OVP_BLANK_CYC = (OVP_BLANK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned NOSYNC_MS = 10;
  localparam logic [CNT_W-1:0] NOSYNC_CYC_DEF = CNT_W'(NOSYNC_MS * 1_000_000 / CLK_NS);
  localparam int unsigned WAKE_DEF_HZ = 200;
  localparam logic [CNT_W-1:0] WAKE_CYC_DEF = CNT_W'(CLK_HZ / WAKE_DEF_HZ);
  localparam int unsigned RESTART_MS = 20;
  localparam logic [CNT_W-1:0] RESTART_CYC_DEF = CNT_W'(RESTART_MS * 1_000_000 / CLK_NS);
  // Load current and valley mapping
  localparam logic [9:0] BURST_ENTRY_UA = 10'd560;
  localparam logic [9:0] MIN_CONV_UA = 10'd610;
  localparam logic [5:0] VALLEY_MIN = 6'd1;
  localparam logic [5:0] VALLEY_MAX = 6'd32;
  localparam logic [6:0] VALLEY_JUMP = 7'd10;
  localparam logic [7:0] PLIM_PCT = 8'd85;
  localparam logic [7:0] PCT_FULL = 8'd100;
  // Comparator reference levels, millivolts; over-temperature in degrees C
  localparam int unsigned BROWN_IN_MV = 647;
  localparam int unsigned CURRENT_LIMIT_MV = 610;
  localparam int unsigned HARD_CURRENT_MV = 1210;
  localparam int unsigned SUPPLY_WAKE_MV = 7600;
  localparam int unsigned SUPPLY_BURST_STOP_MV = 8100;
  localparam int unsigned SUPPLY_ACTIVATE_MV = 12500;
  localparam int unsigned SUPPLY_DEACTIVATE_MV = 6600;
  localparam int unsigned SUPPLY_OV_MV = 25000;
  localparam int unsigned LOAD_SENSE_OV_MV = 2700;
  localparam int unsigned OVER_TEMP_C = 130;
  // Register map, byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ONTIME = 12'h004;
  localparam logic [11:0] REG_REFPULSE = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00c;
  localparam logic [11:0] REG_EVENTS = 12'h010;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned STS_VALLEY_LSB = 8;
  localparam int unsigned EVT_W = 7;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [15:0] ONTIME_RST = 16'h0100;
  localparam logic [15:0] REFPULSE_RST = 16'h01f4;
  typedef enum logic [1:0] {GS_IDLE, GS_ON, GS_OFF} fvbp_gate_st_t;
endpackage

// ==== rtl/fvbp_persist.sv ====
// Purpose: Persistence filter, flags a level held for COUNT cycles
// Assumes: Level is already synchronous to clk
// Notes: Hold freezes the count; a low level clears it only while hold is low
`timescale 1ns/100ps
module fvbp_persist #(
  parameter int unsigned COUNT = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Filter
  input wire logic level,
  input wire logic hold,
  output logic hit
);
  localparam int unsigned W = $clog2(COUNT + 1);
  localparam logic [W-1:0] TOP = W'(COUNT);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (!hold) begin
      if (!level) begin
        cnt_q <= '0;
      end else if (cnt_q != TOP) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign hit = (cnt_q == TOP);
endmodule // fvbp_persist

// ==== rtl/fvbp_core.sv ====
// Purpose: Valley selection, burst control and protection sequencing
// Assumes: Comparator pins asynchronous; load sample port on clk
// Notes: APB slave, two-cycle access phase
// Contract
// - At brown-in, cap on-time to 85 percent
// - 560 uA separates valley and burst operation
// - Per half cycle apply previous lowest valley
// - Hold valley in half cycle, vary on-time
// - Valley decrease applies immediately
// - Increase of ten applies now, else later
// - Off-time reaching 47 us starts pulse
// - Unsynced: 10 ms or last period
// - Burst wake samples, applies valley at once
// - Burst duty sets pulsing length at once
// - Sample at or above 610 skips burst
// - Supply wake starts burst until stop level
// - Supply wake drops turn-on-delay pull-up
// - Current limit past blanking ends cycle
// - Hard current within window raises fault
// - Lockout hysteresis 12.5 V on, 6.6 V off
// - Supply above 25 V raises fault
// - Demag sense above limit raises overvoltage
// - Junction at 130 C raises fault
// - Load-sense overvoltage blocks all switching
// - Output overvoltage enters auto-restart
// - Load-sense block after 20 us, release
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module fvbp_core import fvbp_pkg::*; #(
  parameter logic [CNT_W-1:0] NOSYNC_CYC = NOSYNC_CYC_DEF,
  parameter logic [CNT_W-1:0] WAKE_CYC = WAKE_CYC_DEF,
  parameter logic [CNT_W-1:0] RESTART_CYC = RESTART_CYC_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator pins
  input wire logic cs_above_limit,
  input wire logic cs_above_hard,
  input wire logic supply_above_activate,
  input wire logic supply_below_deactivate,
  input wire logic supply_above_overvoltage,
  input wire logic supply_below_wake,
  input wire logic supply_above_burst_stop,
  input wire logic junction_hot,
  input wire logic load_sense_above_ov,
  input wire logic load_sense_below_release,
  input wire logic winding_sense_pin,
  input wire logic line_half_sync,
  input wire logic brown_in_level,
  // Load mapping, same clock
  input wire logic load_vld,
  input wire logic [9:0] load_current_ua,
  input wire logic [5:0] load_valley,
  input wire logic [7:0] load_burst_duty,
  // Power stage
  output logic gate_drive_out,
  output logic turn_on_delay_pin
);
  localparam int unsigned NPIN = 13;
  logic [NPIN-1:0] pin_s1_q, pin_s2_q;
  logic lim_s, hard_s, von_s, vmin_s, vov_s, wake_s, stop_s, hot_s;
  logic lsov_s, lsrel_s, wind_s, line_s, brown_s;
  logic wake_d_q, wind_d_q, line_d_q;

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {cs_above_limit, cs_above_hard, supply_above_activate,
                   supply_below_deactivate, supply_above_overvoltage, supply_below_wake,
                   supply_above_burst_stop, junction_hot, load_sense_above_ov,
                   load_sense_below_release, winding_sense_pin, line_half_sync,
                   brown_in_level};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign {lim_s, hard_s, von_s, vmin_s, vov_s, wake_s, stop_s, hot_s,
          lsov_s, lsrel_s, wind_s, line_s, brown_s} = pin_s2_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_d_q <= 1'b0;
      wind_d_q <= 1'b0;
      line_d_q <= 1'b0;
    end else begin
      wake_d_q <= wake_s;
      wind_d_q <= wind_s;
      line_d_q <= line_s;
    end
  end

  logic vcc_wake_rise, valley_edge, line_rise;
  assign vcc_wake_rise = wake_s & ~wake_d_q;
  assign valley_edge = wind_d_q & ~wind_s;
  assign line_rise = line_s & ~line_d_q;

  // Registers
  logic ctrl_en_q;
  logic [15:0] ontime_q, refpulse_q;
  logic [EVT_W-1:0] events_q, evt;
  logic apb_wr, apb_rd;
  assign apb_wr = psel & penable & pwrite & pready;
  assign apb_rd = psel & penable & ~pwrite & ~pready;

  fvbp_gate_st_t st_q;
  logic gate_q, supply_ok_q, fault_active_q, ls_block_q, burst_q, burst_on_q, burst_vcc_q;
  logic lost_q;
  logic [5:0] valley_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_en_q <= CTRL_EN_RST;
      ontime_q <= ONTIME_RST;
      refpulse_q <= REFPULSE_RST;
    end else if (apb_wr) begin
      if (paddr == REG_CTRL) ctrl_en_q <= pwdata[CTRL_EN_BIT];
      if (paddr == REG_ONTIME) ontime_q <= pwdata[15:0];
      if (paddr == REG_REFPULSE) refpulse_q <= pwdata[15:0];
    end
  end

  // Event flags, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      events_q <= '0;
    end else if (apb_wr && paddr == REG_EVENTS) begin
      events_q <= (events_q & ~pwdata[EVT_W-1:0]) | evt;
    end else begin
      events_q <= events_q | evt;
    end
  end

  logic [31:0] rd_data;
  logic rd_ok;
  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    unique case (paddr)
      REG_CTRL: rd_data[CTRL_EN_BIT] = ctrl_en_q;
      REG_ONTIME: rd_data[15:0] = ontime_q;
      REG_REFPULSE: rd_data[15:0] = refpulse_q;
      REG_STATUS: rd_data = {18'h0, valley_q, 2'h0, lost_q, burst_on_q, ls_block_q,
                             fault_active_q, burst_q, supply_ok_q};
      REG_EVENTS: rd_data[EVT_W-1:0] = events_q;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~rd_ok;
      if (apb_rd) prdata <= rd_data;
    end
  end

  // Protection filters
  logic leb_hit, vov_hit, ovp_hit, otp_hit, lsov_hit, von_hit, vmin_hit, demag;
  logic [5:0] vcnt_q;
  assign demag = (st_q == GS_OFF) && (vcnt_q == 6'd0);
  fvbp_persist #(.COUNT(LEB_CYC)) u_leb (.clk(clk), .sys_rst(sys_rst),
    .level(lim_s & (st_q == GS_ON)), .hold(1'b0), .hit(leb_hit));
  fvbp_persist #(.COUNT(OVP_BLANK_CYC)) u_ovp (.clk(clk), .sys_rst(sys_rst),
    .level(lim_s), .hold(~demag), .hit(ovp_hit));
  fvbp_persist #(.COUNT(SUPPLY_BLANK_CYC)) u_vov (.clk(clk), .sys_rst(sys_rst),
    .level(vov_s), .hold(1'b0), .hit(vov_hit));
  fvbp_persist #(.COUNT(SUPPLY_BLANK_CYC)) u_von (.clk(clk), .sys_rst(sys_rst),
    .level(von_s), .hold(1'b0), .hit(von_hit));
  fvbp_persist #(.COUNT(SUPPLY_BLANK_CYC)) u_vmin (.clk(clk), .sys_rst(sys_rst),
    .level(vmin_s), .hold(1'b0), .hit(vmin_hit));
  fvbp_persist #(.COUNT(OTP_BLANK_CYC)) u_otp (.clk(clk), .sys_rst(sys_rst),
    .level(hot_s), .hold(1'b0), .hit(otp_hit));
  fvbp_persist #(.COUNT(LSOV_BLANK_CYC)) u_lsov (.clk(clk), .sys_rst(sys_rst),
    .level(lsov_s), .hold(1'b0), .hit(lsov_hit));

  logic [2:0] lim_age_q;
  logic hard_evt;
  always_ff @(posedge clk) begin
    if (sys_rst || !lim_s) lim_age_q <= '0;
    else if (lim_age_q <= 3'(HARD_WIN_CYC)) lim_age_q <= lim_age_q + 1'b1;
  end
  assign hard_evt = (st_q == GS_ON) & lim_s & hard_s & (lim_age_q <= 3'(HARD_WIN_CYC));

  logic restart_evt, skip_evt;
  logic [CNT_W-1:0] rs_cnt_q;
  assign restart_evt = hard_evt | vov_hit | ovp_hit | otp_hit;
  assign evt = {skip_evt, leb_hit, lsov_hit, otp_hit, ovp_hit, vov_hit, hard_evt};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_active_q <= 1'b0;
      rs_cnt_q <= '0;
    end else if (restart_evt) begin
      fault_active_q <= 1'b1;
      rs_cnt_q <= '0;
    end else if (fault_active_q) begin
      rs_cnt_q <= rs_cnt_q + 1'b1;
      if (rs_cnt_q == RESTART_CYC - 1'b1) fault_active_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || vmin_hit) supply_ok_q <= 1'b0;
    else if (von_hit) supply_ok_q <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) ls_block_q <= 1'b0;
    else if (lsov_hit) ls_block_q <= 1'b1;
    else if (lsrel_s && !lsov_s) ls_block_q <= 1'b0;
  end

  logic [CNT_W-1:0] hc_cnt_q, period_q, hc_lim, wake_lim;
  logic seen_q, period_ok_q, hc_bound;
  assign hc_lim = (lost_q && period_ok_q) ? period_q : NOSYNC_CYC;
  assign hc_bound = line_rise | (hc_cnt_q == hc_lim - 1'b1);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hc_cnt_q <= '0;
      period_q <= '0;
      seen_q <= 1'b0;
      period_ok_q <= 1'b0;
      lost_q <= 1'b0;
    end else if (line_rise) begin
      hc_cnt_q <= '0;
      seen_q <= 1'b1;
      lost_q <= 1'b0;
      if (seen_q) begin
        period_q <= hc_cnt_q;
        period_ok_q <= 1'b1;
      end
    end else if (hc_bound) begin
      hc_cnt_q <= '0;
      lost_q <= 1'b1;
    end else begin
      hc_cnt_q <= hc_cnt_q + 1'b1;
    end
  end

  logic [9:0] cur_q;
  logic [5:0] mv;
  assign mv = (load_valley < VALLEY_MIN) ? VALLEY_MIN :
              (load_valley > VALLEY_MAX) ? VALLEY_MAX : load_valley;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_q <= '0;
      burst_q <= 1'b0;
    end else if (load_vld) begin
      cur_q <= load_current_ua;
      burst_q <= (load_current_ua >= BURST_ENTRY_UA);
    end
  end

  // Burst wake timing
  logic [CNT_W-1:0] wake_cnt_q, blen_q, bcnt_q;
  logic [7:0] duty_q;
  logic wake_tmr, wake_take;
  logic [CNT_W+7:0] blen_full;
  assign wake_lim = period_ok_q ? {1'b0, period_q[CNT_W-1:1]} : WAKE_CYC;
  assign wake_tmr = burst_q && (wake_cnt_q == wake_lim - 1'b1);
  assign skip_evt = wake_tmr & ~vcc_wake_rise & ~burst_vcc_q & (cur_q >= MIN_CONV_UA);
  assign wake_take = burst_q & (vcc_wake_rise | (wake_tmr & ~burst_vcc_q & ~skip_evt));
  assign blen_full = (CNT_W+8)'(wake_lim) * (CNT_W+8)'(duty_q);
  always_ff @(posedge clk) begin
    if (sys_rst || !burst_q || wake_tmr) wake_cnt_q <= '0;
    else wake_cnt_q <= wake_cnt_q + 1'b1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) duty_q <= '0;
    else if (load_vld) duty_q <= load_burst_duty;
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !burst_q) begin
      burst_on_q <= 1'b0;
      burst_vcc_q <= 1'b0;
      blen_q <= '0;
      bcnt_q <= '0;
    end else if (vcc_wake_rise) begin
      burst_on_q <= 1'b1;
      burst_vcc_q <= 1'b1;
    end else if (burst_vcc_q) begin
      if (stop_s) begin
        burst_on_q <= 1'b0;
        burst_vcc_q <= 1'b0;
      end
    end else if (wake_tmr) begin
      burst_on_q <= ~skip_evt & (duty_q != 8'h00);
      blen_q <= blen_full[CNT_W+7:8];
      bcnt_q <= '0;
    end else if (burst_on_q) begin
      bcnt_q <= bcnt_q + 1'b1;
      if (bcnt_q + 1'b1 >= blen_q) burst_on_q <= 1'b0;
    end
  end

  // pull-up off from wake to stop level
  always_ff @(posedge clk) begin
    if (sys_rst) turn_on_delay_pin <= 1'b1;
    else if (vcc_wake_rise) turn_on_delay_pin <= 1'b0;
    else if (stop_s) turn_on_delay_pin <= 1'b1;
  end

  // Valley hysteresis
  logic [5:0] min_q;
  logic min_seen_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      valley_q <= VALLEY_MIN;
      min_q <= VALLEY_MAX;
      min_seen_q <= 1'b0;
    end else if (wake_take) begin
      valley_q <= mv;
    end else if (!burst_q) begin
      if (hc_bound) begin
        if (load_vld && (!min_seen_q || mv < min_q)) valley_q <= mv;
        else if (min_seen_q) valley_q <= min_q;
        min_q <= load_vld ? mv : VALLEY_MAX;
        min_seen_q <= load_vld;
      end else if (load_vld) begin
        if (mv < valley_q || {1'b0, mv} >= {1'b0, valley_q} + VALLEY_JUMP)
          valley_q <= mv;
        if (!min_seen_q || mv < min_q) min_q <= mv;
        min_seen_q <= 1'b1;
      end
    end
  end

  logic [23:0] plim_prod;
  logic [15:0] ton_lim, ton_eff;
  assign plim_prod = (24'(refpulse_q) * 24'(PLIM_PCT)) / 24'(PCT_FULL);
  assign ton_lim = brown_s ? plim_prod[15:0] : refpulse_q;
  // on-time is one regulation knob, beside valley and burst duty
  assign ton_eff = (ontime_q < ton_lim) ? ontime_q : ton_lim;

  logic sw_ok;
  assign sw_ok = ctrl_en_q & supply_ok_q & ~fault_active_q & ~ls_block_q &
                 (~burst_q | burst_on_q);

  fvbp_gate_st_t st_d;
  logic [15:0] ton_cnt_q;
  logic [10:0] off_cnt_q;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      GS_IDLE: if (sw_ok) st_d = GS_ON;
      GS_ON: if (!sw_ok || leb_hit || ton_cnt_q + 1'b1 >= ton_eff) st_d = GS_OFF;
      GS_OFF: begin
        if (!sw_ok) st_d = GS_IDLE;
        else if ((valley_edge && vcnt_q + 1'b1 >= valley_q) ||
                 off_cnt_q == 11'(OFF_MAX_CYC - 1)) st_d = GS_ON;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= GS_IDLE;
      ton_cnt_q <= '0;
      off_cnt_q <= '0;
      vcnt_q <= '0;
    end else begin
      st_q <= st_d;
      ton_cnt_q <= (st_d == GS_ON && st_q == GS_ON) ? ton_cnt_q + 1'b1 : '0;
      off_cnt_q <= (st_d == GS_OFF && st_q == GS_OFF) ? off_cnt_q + 1'b1 : '0;
      if (st_d != GS_OFF) vcnt_q <= '0;
      else if (st_q == GS_OFF && valley_edge) vcnt_q <= vcnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) gate_q <= 1'b0;
    else gate_q <= (st_d == GS_ON) & sw_ok & ~restart_evt;
  end
  assign gate_drive_out = gate_q;

  // Checks
  sequence s_limit_held;
    (lim_s && st_q == GS_ON)[*4];
  endsequence
  sequence s_wake_skip;
    wake_tmr && !vcc_wake_rise && !burst_vcc_q && cur_q >= MIN_CONV_UA;
  endsequence
  a_gate_fault_low: assert property (@(posedge clk) disable iff (sys_rst)
    fault_active_q |=> !gate_q) else $error("gate high during fault");
  a_lockout_low: assert property (@(posedge clk) disable iff (sys_rst)
    !supply_ok_q |=> !gate_q) else $error("gate high in lockout");
  a_ls_block_low: assert property (@(posedge clk) disable iff (sys_rst)
    ls_block_q |=> !gate_q) else $error("gate high while blocked");
  a_leb_cut_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    s_limit_held |-> ##[1:2] !gate_q) else $error("current limit missed");
  a_hard_fault_set: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == GS_ON && $rose(lim_s) ##0 hard_s |=> fault_active_q && events_q[0])
    else $error("hard current fault missed");
  a_off_max_start: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == GS_OFF && off_cnt_q == 11'(OFF_MAX_CYC - 1) && sw_ok && !restart_evt
    |=> gate_q) else $error("off-time limit ignored");
  a_valley_down_now: assert property (@(posedge clk) disable iff (sys_rst)
    load_vld && !burst_q && !wake_take && mv < valley_q |=> valley_q == $past(mv))
    else $error("valley decrease delayed");
  a_valley_small_wait: assert property (@(posedge clk) disable iff (sys_rst)
    load_vld && !burst_q && !hc_bound && mv > valley_q && {1'b0, mv} < {1'b0, valley_q} + VALLEY_JUMP
    |=> $stable(valley_q)) else $error("small valley rise applied early");
  a_burst_skip_off: assert property (@(posedge clk) disable iff (sys_rst)
    s_wake_skip |=> !burst_on_q) else $error("burst not skipped");
  a_vcc_wake_burst: assert property (@(posedge clk) disable iff (sys_rst)
    burst_q && vcc_wake_rise |=> burst_on_q && !turn_on_delay_pin ##1 burst_on_q || stop_s)
    else $error("supply wake burst missing");
endmodule // fvbp_core

// ==== testbench/fvbp_stage_model.sv ====
// Purpose: Power stage stand-in, rings the winding while the switch is off
// Assumes: One valley per RING cycles once ringing is enabled
// Notes: Winding idles high, so no falling edge appears without ringing
`timescale 1ns/100ps
module fvbp_stage_model #(
  parameter int unsigned RING = 30
) (
  // Clock
  input wire logic clk,
  // Stage
  input wire logic gate_drive_out,
  input wire logic valleys_on,
  output logic winding_sense_pin
);
  int unsigned t = 0;
  initial winding_sense_pin = 1'b1;
  always @(posedge clk) begin
    if (gate_drive_out || !valleys_on) begin
      t <= 0;
      winding_sense_pin <= 1'b1;
    end else begin
      t <= (t == RING - 1) ? 0 : t + 1;
      winding_sense_pin <= (t < RING / 2);
    end
  end
endmodule // fvbp_stage_model

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the valley, burst and protection core
// Assumes: Shortened restart, wake and no-sync counts
// Notes: Comparator inputs change right after rising edges
`timescale 1ns/100ps
module testbench;
  import fvbp_pkg::*;
  // Bench signals
  logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [31:0] prdata;
  logic pready, pslverr, gate_drive_out, turn_on_delay_pin, winding_sense_pin, er;
  logic cs_above_limit = 1'b0, cs_above_hard = 1'b0, supply_above_activate = 1'b0;
  logic supply_below_deactivate = 1'b0, supply_above_overvoltage = 1'b0;
  logic supply_below_wake = 1'b0, supply_above_burst_stop = 1'b1, junction_hot = 1'b0;
  logic load_sense_above_ov = 1'b0, load_sense_below_release = 1'b1, line_half_sync = 1'b0;
  logic brown_in_level = 1'b0, load_vld = 1'b0, valleys_on = 1'b0;
  logic [9:0] load_current_ua = 10'h064;
  logic [5:0] load_valley = 6'h01;
  logic [7:0] load_burst_duty = 8'h80;
  int n_fail = 0, num_checks = 0, cyc = 0, w;
  always #20 clk = ~clk;
  fvbp_core #(.NOSYNC_CYC(20'd400), .WAKE_CYC(20'd200), .RESTART_CYC(20'd100)) dut (
    .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cs_above_limit, .cs_above_hard, .supply_above_activate, .supply_below_deactivate,
    .supply_above_overvoltage, .supply_below_wake, .supply_above_burst_stop, .junction_hot,
    .load_sense_above_ov, .load_sense_below_release, .winding_sense_pin, .line_half_sync,
    .brown_in_level, .load_vld, .load_current_ua, .load_valley, .load_burst_duty,
    .gate_drive_out, .turn_on_delay_pin);
  fvbp_stage_model #(.RING(30)) stage (.clk, .gate_drive_out, .valleys_on,
    .winding_sense_pin);
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for a gate rise, then counts its high cycles
  task automatic gate_hi();
    int k;
    k = 0;
    w = 0;
    while (gate_drive_out !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    while (gate_drive_out === 1'b1 && w < 3000) begin
      @(posedge clk);
      w++;
    end
  endtask
  task automatic gate_lo();
    gate_hi();
    w = 0;
    while (gate_drive_out !== 1'b1 && w < 3000) begin
      @(posedge clk);
      w++;
    end
  endtask
  task automatic load(input logic [5:0] v);
    @(posedge clk);
    load_vld <= 1'b1;
    load_valley <= v;
    @(posedge clk);
    load_vld <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
  endtask
  task automatic t_reset();
    chk("gate", gate_drive_out, 1'b0);
    chk("pullup", turn_on_delay_pin, 1'b1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(1'b0, REG_ONTIME, 32'h0);
    chk("ontime", rd, 32'h100);
    apb(1'b0, REG_REFPULSE, 32'h0);
    chk("refpulse", rd, 32'h1f4);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_pulse();
    supply_above_activate <= 1'b1;
    repeat (40) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("supply ok", rd[0], 1'b1);
    load(6'h01);
    apb(1'b1, REG_ONTIME, 32'h14);
    apb(1'b1, REG_CTRL, 32'h1);
    gate_hi();
    gate_hi();
    chk("ontime", w, 20);
    brown_in_level <= 1'b1;
    apb(1'b1, REG_REFPULSE, 32'h14);
    apb(1'b1, REG_ONTIME, 32'h64);
    gate_hi();
    gate_hi();
    chk("capped", w, 17);
    brown_in_level <= 1'b0;
    apb(1'b1, REG_ONTIME, 32'h14);
    gate_lo();
    chk("offmax", w >= 1175 && w <= 1177, 1'b1);
    valleys_on <= 1'b1;
    gate_lo();
    chk("valley", w < 100, 1'b1);
    $display("test pulse done");
  endtask
  task automatic t_valley();
    // One line edge, then boundaries every 400 cycles
    line_half_sync <= 1'b1;
    repeat (4) @(posedge clk);
    line_half_sync <= 1'b0;
    load(6'h08);
    chk("small rise", rd[13:8], 6'h01);
    repeat (385) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("held", rd[13:8], 6'h01);
    repeat (10) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("half cycle", rd[13:8], 6'h08);
    load(6'h14);
    chk("big rise", rd[13:8], 6'h14);
    load(6'h03);
    chk("drop", rd[13:8], 6'h03);
    load(6'h01);
    $display("test valley done");
  endtask
  task automatic t_burst();
    int n;
    load_current_ua <= BURST_ENTRY_UA - 10'h001;
    load(6'h05);
    chk("qr mode", rd[1], 1'b0);
    load_current_ua <= BURST_ENTRY_UA;
    load(6'h07);
    chk("burst mode", rd[1], 1'b1);
    while (rd[4] !== 1'b1) apb(1'b0, REG_STATUS, 32'h0);
    chk("burst valley", rd[13:8], 6'h07);
    // Half duty of 200 cycles, polled every 4 cycles
    for (n = 0; rd[4] === 1'b1; n++) apb(1'b0, REG_STATUS, 32'h0);
    chk("burst length", n >= 24 && n <= 26, 1'b1);
    load_current_ua <= MIN_CONV_UA;
    load(6'h07);
    repeat (200) @(posedge clk);
    apb(1'b0, REG_EVENTS, 32'h0);
    chk("skip evt", rd[6], 1'b1);
    supply_below_wake <= 1'b1;
    supply_above_burst_stop <= 1'b0;
    repeat (6) @(posedge clk);
    supply_below_wake <= 1'b0;
    repeat (300) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("supply burst", rd[4], 1'b1);
    supply_above_burst_stop <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("burst stop", rd[4], 1'b0);
    load_current_ua <= 10'h064;
    load(6'h01);
    $display("test burst done");
  endtask
  task automatic t_current();
    cs_above_limit <= 1'b1;
    gate_hi();
    gate_hi();
    chk("limit cut", w < 12, 1'b1);
    cs_above_limit <= 1'b0;
    apb(1'b0, REG_EVENTS, 32'h0);
    chk("limit evt", rd[5], 1'b1);
    apb(1'b1, REG_EVENTS, 32'h7f);
    gate_hi();
    @(posedge gate_drive_out);
    cs_above_limit <= 1'b1;
    cs_above_hard <= 1'b1;
    repeat (8) @(posedge clk);
    chk("hard gate", gate_drive_out, 1'b0);
    cs_above_limit <= 1'b0;
    cs_above_hard <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
    chk("fault", rd[2], 1'b1);
    apb(1'b0, REG_EVENTS, 32'h0);
    chk("hard evt", rd[0], 1'b1);
    gate_hi();
    chk("restart", w, 20);
    $display("test current done");
  endtask
  task automatic t_supply();
    supply_below_wake <= 1'b1;
    supply_above_burst_stop <= 1'b0;
    repeat (6) @(posedge clk);
    chk("pullup off", turn_on_delay_pin, 1'b0);
    supply_below_wake <= 1'b0;
    supply_above_burst_stop <= 1'b1;
    repeat (6) @(posedge clk);
    chk("pullup on", turn_on_delay_pin, 1'b1);
    load_sense_above_ov <= 1'b1;
    load_sense_below_release <= 1'b0;
    repeat (470) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("not yet", rd[3], 1'b0);
    repeat (40) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("blocked", rd[3], 1'b1);
    chk("blocked gate", gate_drive_out, 1'b0);
    load_sense_above_ov <= 1'b0;
    load_sense_below_release <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("released", rd[3], 1'b0);
    supply_below_deactivate <= 1'b1;
    repeat (40) @(posedge clk);
    chk("lockout gate", gate_drive_out, 1'b0);
    $display("test supply done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_pulse();
    t_valley();
    t_burst();
    t_current();
    t_supply();
    complete_run();
  end
endmodule // testbench
